// >>> rtl/puc_defines.svh
// constants for the pattern-unlocked clock access block
`ifndef PUC_DEFINES_SVH
`define PUC_DEFINES_SVH
`define PUC_CLK_MHZ      40
`define PUC_PAT_BITS     64
`define PUC_PAT_LAST     6'h3f
`define PUC_PATTERN      64'h5ca3_3ac5_5ca3_3ac5
`define PUC_RST_IGN_BIT  36
`define PUC_CLOCK_RESET  64'h0000_0000_0000_0000
`define PUC_NSYNC        7
`define PUC_SI_CE        0
`define PUC_SI_OE        1
`define PUC_SI_WE        2
`define PUC_SI_DIN       3
`define PUC_SI_PF        4
`define PUC_SI_ROM       5
`define PUC_SI_RST       6
`define PUC_SYNC_IDLE    7'h47
`define PUC_T_WP_NS      55
`define PUC_T_WR_NS      10
`define PUC_SYNC_MARGIN  5
`define PUC_RECOV_MARGIN 7
`define PUC_STROBE_CYC   (((`PUC_T_WP_NS * `PUC_CLK_MHZ) + 999) / 1000 + `PUC_SYNC_MARGIN)
`define PUC_RECOV_CYC    (((`PUC_T_WR_NS * `PUC_CLK_MHZ) + 999) / 1000 + `PUC_RECOV_MARGIN)
`define PUC_FIFO_DEPTH   4
`define PUC_CMD_W        3
`endif

// >>> rtl/puc_pkg.sv
// types for the pattern-unlocked clock access block
package puc_pkg;
  typedef enum logic [1:0] {
    DEV_DISARM = 2'b00,
    DEV_MATCH  = 2'b01,
    DEV_REJECT = 2'b10,
    DEV_XFER   = 2'b11
  } puc_dev_state_t;

  typedef enum logic [1:0] {
    CMD_READ   = 2'b00,
    CMD_WRITE  = 2'b01,
    CMD_UNLOCK = 2'b10
  } puc_cmd_kind_t;

  typedef enum logic [1:0] {
    HST_IDLE   = 2'b00,
    HST_STROBE = 2'b01,
    HST_RECOV  = 2'b10
  } puc_host_state_t;

  typedef struct packed {
    logic [6:0]     s1;
    logic [6:0]     s2;
    logic [6:0]     s3;
    logic [6:0]     filt;
    logic           rd_act;
    logic           wr_act;
    logic           dlat;
    puc_dev_state_t st;
    logic [5:0]     ptr;
    logic [63:0]    shadow;
    logic [63:0]    regs;
    logic           dirty;
    logic           dout;
    logic           dout_oe;
    logic           ceo_n;
    logic           unl;
  } puc_dev_reg_t;

  typedef struct packed {
    puc_host_state_t st;
    logic [3:0]      cnt;
    logic            unl;
    logic [6:0]      useq;
    logic            ce_n;
    logic            oe_n;
    logic            we_n;
    logic            d;
    logic            rd_valid;
    logic            rd_bit;
    logic            busy;
  } puc_host_reg_t;
endpackage : puc_pkg

// >>> rtl/puc_bus_if.sv
// shared memory socket signals between host and clock device
`timescale 1ns/100ps
interface puc_bus_if;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic ceo_n;

  modport dev (
    input  ce_n,
    input  oe_n,
    input  we_n,
    input  din,
    output dout,
    output dout_oe,
    output ceo_n
  );

  modport host (
    output ce_n,
    output oe_n,
    output we_n,
    output din,
    input  dout,
    input  dout_oe,
    input  ceo_n
  );
endinterface : puc_bus_if

// >>> rtl/puc_dev.sv
// device end: pattern recognition, serial clock transfer and chip enable gating
`timescale 1ns/100ps
`include "puc_defines.svh"

module puc_dev (
  input  wire logic        clk,
  input  wire logic        rst_n,
  puc_bus_if.dev           bus,
  input  wire logic        power_fail,
  input  wire logic        rom_mode,
  input  wire logic        reset_pin_n,
  output logic [63:0]      clock_data,
  output logic             unlocked
);
  import puc_pkg::*;

  localparam puc_dev_reg_t DEV_RST = '{
    s1:      `PUC_SYNC_IDLE,
    s2:      `PUC_SYNC_IDLE,
    s3:      `PUC_SYNC_IDLE,
    filt:    `PUC_SYNC_IDLE,
    st:      DEV_DISARM,
    regs:    `PUC_CLOCK_RESET,
    ceo_n:   1'b1,
    default: '0
  };

  // a literal cannot be bit-selected, so the pattern is held as a constant vector
  localparam logic [63:0] PAT = `PUC_PATTERN;

  puc_dev_reg_t r;
  puc_dev_reg_t next_r;
  logic         rd_now;
  logic         wr_now;
  logic         rd_start;
  logic         rd_end;
  logic         wr_end;
  logic         pf;
  logic         abort;
  logic         last;
  logic [63:0]  sh;

  always_comb begin
    next_r = r;
    sh     = r.shadow;
    // three stage synchronisers, a change counts once stages two and three agree
    next_r.s1 = {reset_pin_n, rom_mode, power_fail, bus.din, bus.we_n, bus.oe_n, bus.ce_n};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < `PUC_NSYNC; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.filt[i] = r.s3[i];
      end
    end
    // only cycles with chip enable low count as device cycles
    rd_now = ~r.filt[`PUC_SI_CE] & ~r.filt[`PUC_SI_OE];
    wr_now = ~r.filt[`PUC_SI_CE] & ~r.filt[`PUC_SI_WE];
    next_r.rd_act = rd_now;
    next_r.wr_act = wr_now;
    rd_start = rd_now & ~r.rd_act;
    rd_end   = ~rd_now & r.rd_act;
    wr_end   = ~wr_now & r.wr_act;
    if (wr_now) begin
      next_r.dlat = r.filt[`PUC_SI_DIN];
    end
    pf    = r.filt[`PUC_SI_PF];
    abort = pf | (~r.filt[`PUC_SI_RST] & ~r.regs[`PUC_RST_IGN_BIT]);
    last  = (r.ptr == `PUC_PAT_LAST);
    case (r.st)
      DEV_DISARM, DEV_MATCH, DEV_REJECT: begin
        if (rd_end) begin
          next_r.st  = DEV_MATCH;
          next_r.ptr = '0;
        end else if (wr_end && r.st == DEV_MATCH) begin
          if (r.dlat == PAT[r.ptr]) begin
            if (last) begin
              next_r.st     = DEV_XFER;
              next_r.ptr    = '0;
              next_r.shadow = r.regs;
              next_r.dirty  = 1'b0;
            end else begin
              next_r.ptr = r.ptr + 6'h01;
            end
          end else begin
            next_r.st = DEV_REJECT;
          end
        end
      end
      DEV_XFER: begin
        if (rd_start) begin
          next_r.dout    = r.shadow[r.ptr];
          next_r.dout_oe = 1'b1;
        end
        if (wr_end) begin
          sh[r.ptr]     = r.dlat;
          next_r.shadow = sh;
          next_r.dirty  = 1'b1;
        end
        if (rd_end || wr_end) begin
          next_r.dout_oe = 1'b0;
          if (last) begin
            next_r.st  = DEV_DISARM;
            next_r.ptr = '0;
            if (r.dirty || wr_end) begin
              next_r.regs = sh;
            end
          end else begin
            next_r.ptr = r.ptr + 6'h01;
          end
        end
      end
      default: begin
        next_r.st = DEV_DISARM;
      end
    endcase
    // abort drops the shadow so the clock registers stay untouched
    if (abort) begin
      next_r.st      = DEV_DISARM;
      next_r.ptr     = '0;
      next_r.dout_oe = 1'b0;
      next_r.regs    = r.regs;
    end
    if (pf) begin
      next_r.ceo_n = ~r.filt[`PUC_SI_ROM];
    end else if (next_r.st == DEV_XFER) begin
      next_r.ceo_n = 1'b1;
    end else begin
      next_r.ceo_n = r.filt[`PUC_SI_CE];
    end
    next_r.unl = (next_r.st == DEV_XFER);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= DEV_RST;
    end else begin
      r <= next_r;
    end
  end

  assign bus.dout    = r.dout;
  assign bus.dout_oe = r.dout_oe;
  assign bus.ceo_n   = r.ceo_n;
  assign clock_data  = r.regs;
  assign unlocked    = r.unl;
endmodule : puc_dev

// >>> rtl/puc_host.sv
// host end: command fifo and bus cycle sequencer with unlock pattern generator
`timescale 1ns/100ps
`include "puc_defines.svh"

module puc_fifo #(
  parameter int W     = `PUC_CMD_W,
  parameter int DEPTH = `PUC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } puc_fifo_reg_t;

  puc_fifo_reg_t r;
  puc_fifo_reg_t next_r;
  logic          push;
  logic          pop;

  always_comb begin
    next_r = r;
    push   = in_valid & r.rdy;
    pop    = (r.cnt != '0) & out_ready;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - (AW + 1)'(1);
    end
    next_r.rdy = (next_r.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{rdy: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign in_ready  = r.rdy;
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
endmodule : puc_fifo

module puc_host (
  input  wire logic            clk,
  input  wire logic            rst_n,
  puc_bus_if.host              bus,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  puc_pkg::puc_cmd_kind_t cmd_kind,
  input  wire logic            cmd_bit,
  output logic                 rd_valid,
  output logic                 rd_bit,
  output logic                 busy
);
  import puc_pkg::*;

  localparam logic [3:0] STROBE_LAST = 4'(`PUC_STROBE_CYC - 1);
  localparam logic [3:0] RECOV_LAST  = 4'(`PUC_RECOV_CYC - 1);
  localparam logic [6:0] UNL_LAST    = 7'(`PUC_PAT_BITS);
  localparam logic [63:0] PAT        = `PUC_PATTERN;

  puc_host_reg_t             r;
  puc_host_reg_t             next_r;
  logic                      f_valid;
  logic                      f_ready;
  logic [`PUC_CMD_W-1:0]     f_data;
  logic                      go;
  logic                      go_wr;
  logic                      go_bit;

  puc_fifo #(
    .W     (`PUC_CMD_W),
    .DEPTH (`PUC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_kind, cmd_bit}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  always_comb begin
    next_r          = r;
    next_r.rd_valid = 1'b0;
    go              = 1'b0;
    go_wr           = 1'b0;
    go_bit          = 1'b0;
    f_ready         = (r.st == HST_IDLE) && !r.unl;
    case (r.st)
      HST_IDLE: begin
        if (r.unl) begin
          // a read first, then 64 pattern writes with no read between
          go     = 1'b1;
          go_wr  = (r.useq != '0);
          go_bit = (r.useq != '0) ? PAT[6'(r.useq - 7'h01)] : 1'b0;
        end else if (f_valid) begin
          if (f_data[2:1] == CMD_UNLOCK) begin
            next_r.unl  = 1'b1;
            next_r.useq = '0;
          end else begin
            go     = 1'b1;
            go_wr  = (f_data[2:1] == CMD_WRITE);
            go_bit = f_data[0];
          end
        end
      end
      HST_STROBE: begin
        if (r.cnt == '0) begin
          if (!r.oe_n && !r.unl) begin
            next_r.rd_valid = 1'b1;
            next_r.rd_bit   = bus.dout_oe & bus.dout;
          end
          next_r.ce_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.st   = HST_RECOV;
          next_r.cnt  = RECOV_LAST;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      HST_RECOV: begin
        if (r.cnt == '0) begin
          next_r.st = HST_IDLE;
          if (r.unl) begin
            if (r.useq == UNL_LAST) begin
              next_r.unl  = 1'b0;
              next_r.useq = '0;
            end else begin
              next_r.useq = r.useq + 7'h01;
            end
          end
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      default: begin
        next_r.st = HST_IDLE;
      end
    endcase
    if (go) begin
      next_r.st   = HST_STROBE;
      next_r.cnt  = STROBE_LAST;
      next_r.ce_n = 1'b0;
      next_r.oe_n = go_wr;
      next_r.we_n = ~go_wr;
      next_r.d    = go_bit;
    end
    next_r.busy = (next_r.st != HST_IDLE) | next_r.unl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: HST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign bus.ce_n = r.ce_n;
  assign bus.oe_n = r.oe_n;
  assign bus.we_n = r.we_n;
  assign bus.din  = r.d;
  assign rd_valid = r.rd_valid;
  assign rd_bit   = r.rd_bit;
  assign busy     = r.busy;
endmodule : puc_host

// >>> bench/puc_bus_assertions.sv
// assertions on the socket between host and clock device
`timescale 1ns/100ps
module puc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic dout_oe,
  input wire logic ceo_n,
  input wire logic power_fail,
  input wire logic rom_mode,
  input wire logic unlocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HOST_STROBE: assert property ($fell(ce_n) |-> !ce_n [*8] ##1 ce_n [*8])
    else $error("strobe or recovery length wrong");
  AST_READ_PAIR: assert property ($fell(oe_n) |-> !ce_n && we_n)
    else $error("read not qualified by chip enable");
  AST_CEO_FOLLOW: assert property ($fell(ce_n) && !unlocked && !power_fail |-> ##[2:8] !ceo_n)
    else $error("gated enable did not follow falling enable");
  AST_CEO_RISE: assert property ($rose(ce_n) && !power_fail |-> ##[2:8] ceo_n)
    else $error("gated enable did not return high");
  AST_CEO_XFER: assert property (unlocked [*2] |-> ceo_n || rom_mode)
    else $error("memory enabled during transfer");
  AST_PF_RAM: assert property ((power_fail && !rom_mode) [*8] |-> ceo_n)
    else $error("ram mode power fail left memory enabled");
  AST_PF_ROM: assert property ((power_fail && rom_mode) [*8] |-> !ceo_n)
    else $error("rom mode power fail did not drive enable low");
  AST_PF_LOCK: assert property (power_fail [*8] |-> !unlocked && !dout_oe)
    else $error("clock access during power fail");
  AST_DOUT_START: assert property ($rose(dout_oe) |-> !ce_n && !oe_n && unlocked)
    else $error("data out driven outside transfer read");
  AST_DOUT_END: assert property ($rose(oe_n) |-> ##[1:8] !dout_oe)
    else $error("data out not released");
  AST_UNLOCK_IDLE: assert property ($rose(unlocked) |-> ce_n && we_n && !power_fail)
    else $error("unlock outside a write end");
endmodule : puc_chk

// >>> bench/testbench.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module testbench;
  import puc_pkg::*;
  logic          clk, rst_n, cmd_valid, cmd_ready, cmd_bit, rd_valid, rd_bit, busy;
  logic          power_fail, rom_mode, reset_pin_n, unlocked, last_we;
  puc_cmd_kind_t cmd_kind;
  logic [63:0]   clock_data;
  logic [63:0]   pat = 64'h5ca3_3ac5_5ca3_3ac5;
  logic [63:0]   v1  = 64'h0123_4567_89ab_cdef;
  logic [63:0]   v2  = 64'h1e2d_3c4b_5a69_7886;
  logic          q_rd[$];
  logic          q_wr[$];
  int            num_errors, check_count;

  puc_bus_if puc_bus_if_inst ();
  puc_dev puc_dev_inst (.clk(clk), .rst_n(rst_n), .bus(puc_bus_if_inst),
    .power_fail(power_fail), .rom_mode(rom_mode), .reset_pin_n(reset_pin_n),
    .clock_data(clock_data), .unlocked(unlocked));
  puc_host puc_host_inst (.clk(clk), .rst_n(rst_n), .bus(puc_bus_if_inst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_bit(cmd_bit), .rd_valid(rd_valid), .rd_bit(rd_bit), .busy(busy));
  puc_chk puc_chk_inst (.clk(clk), .rst_n(rst_n), .ce_n(puc_bus_if_inst.ce_n),
    .oe_n(puc_bus_if_inst.oe_n), .we_n(puc_bus_if_inst.we_n),
    .dout_oe(puc_bus_if_inst.dout_oe), .ceo_n(puc_bus_if_inst.ceo_n),
    .power_fail(power_fail), .rom_mode(rom_mode), .unlocked(unlocked));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // read results and bits seen at each write start on the wire
  always @(negedge clk) begin
    if (rd_valid === 1'b1) q_rd.push_back(rd_bit);
    if (puc_bus_if_inst.we_n === 1'b0 && last_we === 1'b1) q_wr.push_back(puc_bus_if_inst.din);
    last_we <= puc_bus_if_inst.we_n;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step

  task automatic push(input puc_cmd_kind_t k, input logic b);
    logic ok;
    cmd_kind  = k;
    cmd_bit   = b;
    cmd_valid = 1'b1;
    ok        = 1'b0;
    while (!ok) begin
      @(negedge clk) ok = (cmd_ready === 1'b1);
      @(posedge clk);
    end
    #1;
  endtask : push

  task automatic drain;
    int n;
    n = 0;
    cmd_valid = 1'b0;
    for (int t = 0; t < 30000 && n < 24; t++) begin
      @(negedge clk) n = (busy === 1'b0) ? n + 1 : 0;
    end
    if (n < 24) chk(1, 0);
    step(1);
  endtask : drain

  task automatic wrs(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) push(CMD_WRITE, v[i]);
  endtask : wrs

  task automatic patw(input int n, input int flip);
    push(CMD_READ, 1'b0);
    for (int i = 0; i < n; i++) push(CMD_WRITE, pat[i] ^ (i == flip));
  endtask : patw

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (25000) @(posedge clk);
    num_errors++;
    $display("wrong value at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    rst_n = 1'b0; cmd_valid = 1'b0; cmd_kind = CMD_READ; cmd_bit = 1'b0; last_we = 1'b1;
    power_fail = 1'b0; rom_mode = 1'b0; reset_pin_n = 1'b1; num_errors = 0; check_count = 0;
    step(20);
    rst_n = 1'b1;
    step(1);
    chk(clock_data, 0);
    push(CMD_READ, 1'b0);
    drain;
    chk(q_rd.size(), 1);
    chk(q_rd[0], 0);
    tend("pass through");
    q_wr.delete();
    push(CMD_UNLOCK, 1'b0);
    wrs(v1, 64);
    drain;
    chk(q_wr.size(), 128);
    for (int i = 0; i < 64; i++) begin
      chk(q_wr[i], pat[i]);
      chk(q_wr[64 + i], v1[i]);
    end
    chk(clock_data, v1);
    chk(unlocked, 0);
    tend("unlock and write");
    q_rd.delete();
    push(CMD_UNLOCK, 1'b0);
    for (int i = 0; i < 64; i++) push(CMD_READ, 1'b0);
    drain;
    chk(q_rd.size(), 64);
    for (int i = 0; i < 64; i++) chk(q_rd[i], v1[i]);
    chk(clock_data, v1);
    tend("unlock and read");
    patw(64, 5);
    wrs(v2, 64);
    drain;
    chk(clock_data, v1);
    tend("mismatch");
    patw(30, -1);
    patw(64, -1);
    wrs(v2, 64);
    drain;
    chk(clock_data, v2);
    tend("read abort");
    push(CMD_UNLOCK, 1'b0);
    wrs(~v1, 20);
    drain;
    chk(unlocked, 1);
    power_fail = 1'b1;
    step(12);
    chk(puc_bus_if_inst.ceo_n, 1);
    chk(unlocked, 0);
    rom_mode = 1'b1;
    step(12);
    chk(puc_bus_if_inst.ceo_n, 0);
    power_fail = 1'b0;
    step(12);
    chk(clock_data, v2);
    rom_mode = 1'b0;
    step(8);
    wrs(~v1, 44);
    drain;
    chk(clock_data, v2);
    tend("power fail");
    push(CMD_UNLOCK, 1'b0);
    wrs(~v1, 10);
    drain;
    reset_pin_n = 1'b0;
    step(10);
    reset_pin_n = 1'b1;
    step(10);
    chk(unlocked, 0);
    chk(clock_data, v2);
    tend("reset pin");
    wrap_up();
  end
endmodule : testbench
